//--- rgcr_defs.svh
// register offsets, field positions and reset values for the receiver gain bank
// assumes inclusion by bare name from the bank module
`ifndef RGCR_DEFS_SVH
`define RGCR_DEFS_SVH
`define RGCR_FIRST_GAIN_ADDR 8'h20
`define RGCR_AMB_GAIN_ADDR 8'h21
`define RGCR_FIRST_GAIN_RESET 24'h000000
`define RGCR_AMB_GAIN_RESET 24'h000000
`define RGCR_FIRST_GAIN_MASK 24'h00C7FF
`define RGCR_AMB_GAIN_MASK 24'h0FC7FF
`define RGCR_RES_LSB 0
`define RGCR_CAP_LSB 3
`define RGCR_GAIN_LSB 8
`define RGCR_STAGE_ON_BIT 14
`define RGCR_SPLIT_BIT 15
`define RGCR_CORNER_BIT 15
`define RGCR_CANCEL_LSB 16
`endif

//--- rgcr_pkg.sv
// types shared by the receiver gain register bank
// assumes rgcr_defs.svh is on the include path
package rgcr_pkg;
	typedef logic [7:0] rgcr_addr_t;
	typedef logic [23:0] rgcr_word_t;
	typedef logic [2:0] rgcr_gain_t;
	typedef logic [4:0] rgcr_cap_t;
	typedef logic [2:0] rgcr_res_t;
	typedef logic [3:0] rgcr_cancel_t;
endpackage

//--- rgcr_gain_regs.sv
// receiver gain configuration register bank with analog control outputs
// assumes a simple synchronous strobe bus on clk and static analog lines
// Summary of operation
// - stage two bypassed when its enable is zero, else gain code applies
// - gain code 000..100 selects gains 1, 1.5, 2, 3, 4
// - capacitor field resets to zero; each bit adds its own capacitor
// - any capacitor bit combination allowed; selected values summed
// - resistor code resets to 000; codes select resistors or none
// - ambient gain register sits at 21h and resets to zero
// - ambient register fields placed at documented bits, others zero
// - split bit zero makes second-led settings apply to both phases
// - first-led stage enable at bit 14, split select at bit 15
`include "rgcr_defs.svh"
module rgcr_gain_regs (
	input wire logic clk, // 50 MHz system clock
	input wire logic rst, // async reset, active high
	input wire rgcr_pkg::rgcr_addr_t busAddr, // register address
	input wire rgcr_pkg::rgcr_word_t busWrData, // write data
	input wire logic busWrStrobe, // write strobe
	input wire logic busRdStrobe, // read strobe
	output rgcr_pkg::rgcr_word_t busRdData, // read data, cycle after strobe
	output logic ledASecondStageOn, // stage two enable, first phase
	output rgcr_pkg::rgcr_gain_t ledASecondStageGain, // stage two gain, first phase
	output rgcr_pkg::rgcr_cap_t ledAFeedbackCap, // capacitor select, first phase
	output rgcr_pkg::rgcr_res_t ledAFeedbackRes, // resistor select, first phase
	output logic ledBSecondStageOn, // stage two enable, second phase
	output rgcr_pkg::rgcr_gain_t ledBSecondStageGain, // stage two gain, second phase
	output rgcr_pkg::rgcr_cap_t ledBFeedbackCap, // capacitor select, second phase
	output rgcr_pkg::rgcr_res_t ledBFeedbackRes, // resistor select, second phase
	output rgcr_pkg::rgcr_cancel_t cancelCurrentCode, // ambient cancellation current
	output logic filterCornerSelect // filter corner select
);
	import rgcr_pkg::*;

	rgcr_word_t firstGain_reg;
	rgcr_word_t firstGain_next;
	rgcr_word_t ambGain_reg;
	rgcr_word_t ambGain_next;
	rgcr_word_t rdData_reg;
	rgcr_word_t rdData_next;
	logic aOn_reg;
	logic aOn_next;
	logic bOn_reg;
	logic bOn_next;
	logic corner_reg;
	logic corner_next;
	rgcr_gain_t aGain_reg;
	rgcr_gain_t aGain_next;
	rgcr_gain_t bGain_reg;
	rgcr_gain_t bGain_next;
	rgcr_cap_t aCap_reg;
	rgcr_cap_t aCap_next;
	rgcr_cap_t bCap_reg;
	rgcr_cap_t bCap_next;
	rgcr_res_t aRes_reg;
	rgcr_res_t aRes_next;
	rgcr_res_t bRes_reg;
	rgcr_res_t bRes_next;
	rgcr_cancel_t cancel_reg;
	rgcr_cancel_t cancel_next;
	logic splitGain;
	logic wrFirst;
	logic wrAmb;
	logic rdFirst;
	logic rdAmb;

	function automatic logic hit(input rgcr_addr_t a, input rgcr_addr_t target);
		hit = (a == target);
	endfunction

	// field pickers shared by both phases so the two decoders cannot drift apart
	function automatic logic stage_on(input rgcr_word_t w);
		stage_on = w[`RGCR_STAGE_ON_BIT];
	endfunction

	function automatic rgcr_gain_t stage_gain(input rgcr_word_t w);
		// bypassed stage shows unity so the decoder never sees a stale code
		if (w[`RGCR_STAGE_ON_BIT]) begin
			stage_gain = w[`RGCR_GAIN_LSB +: 3];
		end else begin
			stage_gain = 3'h0;
		end
	endfunction

	function automatic rgcr_cap_t feedback_cap(input rgcr_word_t w);
		feedback_cap = w[`RGCR_CAP_LSB +: 5];
	endfunction

	function automatic rgcr_res_t feedback_res(input rgcr_word_t w);
		feedback_res = w[`RGCR_RES_LSB +: 3];
	endfunction

	// decoded bus strobes, shared by the register groups and the read port
	assign wrFirst = busWrStrobe && hit(busAddr, `RGCR_FIRST_GAIN_ADDR);
	assign wrAmb = busWrStrobe && hit(busAddr, `RGCR_AMB_GAIN_ADDR);
	assign rdFirst = busRdStrobe && hit(busAddr, `RGCR_FIRST_GAIN_ADDR);
	assign rdAmb = busRdStrobe && hit(busAddr, `RGCR_AMB_GAIN_ADDR);

	// first-led register; unwritable bits are masked so they always read zero
	always_comb begin
		firstGain_next = firstGain_reg;
		if (wrFirst) begin
			firstGain_next = busWrData & `RGCR_FIRST_GAIN_MASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			firstGain_reg <= `RGCR_FIRST_GAIN_RESET;
		end else begin
			firstGain_reg <= firstGain_next;
		end
	end

	// ambient register, masked the same way
	always_comb begin
		ambGain_next = ambGain_reg;
		if (wrAmb) begin
			ambGain_next = busWrData & `RGCR_AMB_GAIN_MASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ambGain_reg <= `RGCR_AMB_GAIN_RESET;
		end else begin
			ambGain_reg <= ambGain_next;
		end
	end

	// read port; unmapped addresses and idle cycles return zero,
	// registered so the data stand exactly one cycle after the strobe
	always_comb begin
		rdData_next = 24'h000000;
		if (rdFirst) begin
			rdData_next = firstGain_reg;
		end
		if (rdAmb) begin
			rdData_next = ambGain_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_reg <= 24'h000000;
		end else begin
			rdData_reg <= rdData_next;
		end
	end

	// split select lives in the first-led register
	assign splitGain = firstGain_reg[`RGCR_SPLIT_BIT];

	// second-phase and ambient lines always follow the ambient register;
	// codes pass raw except the stage-two gain, zeroed while its enable is off; the analog side sums capacitors and maps codes
	always_comb begin
		bOn_next = stage_on(ambGain_reg);
		bGain_next = stage_gain(ambGain_reg);
		bCap_next = feedback_cap(ambGain_reg);
		bRes_next = feedback_res(ambGain_reg);
		cancel_next = ambGain_reg[`RGCR_CANCEL_LSB +: 4];
		corner_next = ambGain_reg[`RGCR_CORNER_BIT];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bOn_reg <= 1'b0;
			bGain_reg <= 3'h0;
			bCap_reg <= 5'h00;
			bRes_reg <= 3'h0;
			cancel_reg <= 4'h0;
			corner_reg <= 1'b0;
		end else begin
			bOn_reg <= bOn_next;
			bGain_reg <= bGain_next;
			bCap_reg <= bCap_next;
			bRes_reg <= bRes_next;
			cancel_reg <= cancel_next;
			corner_reg <= corner_next;
		end
	end

	// first phase takes its own fields only when split, else mirrors the second;
	// one output stage for both cases keeps the switch-over glitch free
	always_comb begin
		if (splitGain) begin
			aOn_next = stage_on(firstGain_reg);
			aGain_next = stage_gain(firstGain_reg);
			aCap_next = feedback_cap(firstGain_reg);
			aRes_next = feedback_res(firstGain_reg);
		end else begin
			aOn_next = stage_on(ambGain_reg);
			aGain_next = stage_gain(ambGain_reg);
			aCap_next = feedback_cap(ambGain_reg);
			aRes_next = feedback_res(ambGain_reg);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aOn_reg <= 1'b0;
			aGain_reg <= 3'h0;
			aCap_reg <= 5'h00;
			aRes_reg <= 3'h0;
		end else begin
			aOn_reg <= aOn_next;
			aGain_reg <= aGain_next;
			aCap_reg <= aCap_next;
			aRes_reg <= aRes_next;
		end
	end

	assign busRdData = rdData_reg;
	assign ledASecondStageOn = aOn_reg;
	assign ledASecondStageGain = aGain_reg;
	assign ledAFeedbackCap = aCap_reg;
	assign ledAFeedbackRes = aRes_reg;
	assign ledBSecondStageOn = bOn_reg;
	assign ledBSecondStageGain = bGain_reg;
	assign ledBFeedbackCap = bCap_reg;
	assign ledBFeedbackRes = bRes_reg;
	assign cancelCurrentCode = cancel_reg;
	assign filterCornerSelect = corner_reg;
endmodule // rgcr_gain_regs

//--- rgcr_gain_regs_assertions.sv
// checker on the ports of the receiver gain bank
// assumes one clock domain, registers at 0x20 and 0x21 only
module rgcr_gain_regs_checker (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic busWrStrobe, // write strobe
	input wire logic busRdStrobe, // read strobe
	input wire rgcr_pkg::rgcr_addr_t busAddr, // bus address
	input wire rgcr_pkg::rgcr_word_t busWrData, // write data
	input wire rgcr_pkg::rgcr_word_t busRdData, // read data
	input wire logic ledASecondStageOn, // stage two enable, first phase
	input wire rgcr_pkg::rgcr_gain_t ledASecondStageGain, // stage two gain, first phase
	input wire rgcr_pkg::rgcr_cap_t ledAFeedbackCap, // capacitor select, first phase
	input wire rgcr_pkg::rgcr_res_t ledAFeedbackRes, // resistor select, first phase
	input wire logic ledBSecondStageOn, // stage two enable, second phase
	input wire rgcr_pkg::rgcr_gain_t ledBSecondStageGain, // stage two gain, second phase
	input wire rgcr_pkg::rgcr_cap_t ledBFeedbackCap, // capacitor select, second phase
	input wire rgcr_pkg::rgcr_res_t ledBFeedbackRes, // resistor select, second phase
	input wire rgcr_pkg::rgcr_cancel_t cancelCurrentCode, // cancellation current
	input wire logic filterCornerSelect // filter corner select
);
	timeunit 1ns;
	timeprecision 1ps;
	import rgcr_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// outputs land two edges after the write: register, then output stage
	sequence ambWr; busWrStrobe && busAddr == 8'h21; endsequence
	sequence firstRd; $past(busRdStrobe) && $past(busAddr) == 8'h20; endsequence
	a_rd_idle_zero: assert property (!$past(busRdStrobe) |-> busRdData == 24'h0) else $error("read data not idle");
	a_rd_bad_zero: assert property ($past(busRdStrobe) && !($past(busAddr) inside {8'h20, 8'h21}) |-> busRdData == 24'h0)
		else $error("unmapped read not zero");
	a_first_mask: assert property (firstRd |-> (busRdData & 24'hFF3800) == 24'h0) else $error("reserved bits set");
	a_gain_a_off: assert property (!ledASecondStageOn |-> ledASecondStageGain == 3'h0) else $error("gain a leak");
	a_gain_b_off: assert property (!ledBSecondStageOn |-> ledBSecondStageGain == 3'h0) else $error("gain b leak");
	a_cancel_track: assert property (ambWr |-> ##2 cancelCurrentCode == $past(busWrData[19:16], 2))
		else $error("cancel code wrong");
	a_corner_track: assert property (ambWr |-> ##2 filterCornerSelect == $past(busWrData[15], 2))
		else $error("corner select wrong");
	a_ledb_track: assert property (ambWr |-> ##2 {ledBFeedbackCap, ledBFeedbackRes} == $past(busWrData[7:0], 2))
		else $error("b feedback wrong");
endmodule // rgcr_gain_regs_checker
bind rgcr_gain_regs rgcr_gain_regs_checker u_chk (
	.clk(clk),
	.rst(rst),
	.busWrStrobe(busWrStrobe),
	.busRdStrobe(busRdStrobe),
	.busAddr(busAddr),
	.busWrData(busWrData),
	.busRdData(busRdData),
	.ledASecondStageOn(ledASecondStageOn),
	.ledASecondStageGain(ledASecondStageGain),
	.ledAFeedbackCap(ledAFeedbackCap),
	.ledAFeedbackRes(ledAFeedbackRes),
	.ledBSecondStageOn(ledBSecondStageOn),
	.ledBSecondStageGain(ledBSecondStageGain),
	.ledBFeedbackCap(ledBFeedbackCap),
	.ledBFeedbackRes(ledBFeedbackRes),
	.cancelCurrentCode(cancelCurrentCode),
	.filterCornerSelect(filterCornerSelect)
);

//--- receiver_gain_config_regs_tb.sv
// self-checking bench for the receiver gain bank
// assumes reads answer one cycle after the strobe, outputs two edges after a write
module receiver_gain_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rgcr_pkg::*;
	logic clk = 0, rst = 1, busWrStrobe = 0, busRdStrobe = 0, ledAOn, ledBOn, corner;
	rgcr_addr_t busAddr = 8'h0;
	rgcr_word_t busWrData = 24'h0, busRdData;
	rgcr_gain_t ledAGain, ledBGain;
	rgcr_cap_t ledACap, ledBCap;
	rgcr_res_t ledARes, ledBRes;
	rgcr_cancel_t cancel;
	int err_count = 0, checks = 0;
	wire logic [23:0] ctl = {ledAOn, ledAGain, ledACap, ledARes, ledBOn, ledBGain, ledBCap, ledBRes};
	rgcr_gain_regs dut (.clk(clk), .rst(rst), .busAddr(busAddr), .busWrData(busWrData), .busWrStrobe(busWrStrobe),
		.busRdStrobe(busRdStrobe), .busRdData(busRdData), .ledASecondStageOn(ledAOn), .ledASecondStageGain(ledAGain),
		.ledAFeedbackCap(ledACap), .ledAFeedbackRes(ledARes), .ledBSecondStageOn(ledBOn),
		.ledBSecondStageGain(ledBGain), .ledBFeedbackCap(ledBCap), .ledBFeedbackRes(ledBRes),
		.cancelCurrentCode(cancel), .filterCornerSelect(corner));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input rgcr_addr_t a, input rgcr_word_t d);
		@(posedge clk);
		busAddr <= a;
		busWrData <= d;
		busWrStrobe <= 1'b1;
		@(posedge clk);
		busWrStrobe <= 1'b0;
	endtask
	task automatic rd(input rgcr_addr_t a, input rgcr_word_t e);
		@(posedge clk);
		busAddr <= a;
		busRdStrobe <= 1'b1;
		@(posedge clk);
		busRdStrobe <= 1'b0;
		#1 chk(busRdData, e);
	endtask
	// control outputs settle one edge after the write task returns
	task automatic outs(input logic [23:0] e, input logic [4:0] amb);
		@(posedge clk);
		#1 chk(ctl, e);
		chk({19'h0, cancel, corner}, {19'h0, amb});
	endtask
	task automatic wrap_up;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		wrap_up;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		outs(24'h0, 5'h0);
		rd(8'h20, 24'h0);
		rd(8'h21, 24'h0);
		wr(8'h21, 24'h0FC4FF);
		rd(8'h21, 24'h0FC4FF);
		outs(24'hCFFCFF, 5'h1F);
		wr(8'h20, 24'h00837E);
		outs(24'h07ECFF, 5'h1F);
		rd(8'h20, 24'h00837E);
		for (int g = 0; g < 5; g++) begin
			wr(8'h20, {16'h00C0 | 16'(g), 8'(g)});
			rd(8'h20, {16'h00C0 | 16'(g), 8'(g)});
			chk(ctl, {1'b1, 3'(g), 5'h0, 3'(g), 12'hCFF});
		end
		wr(8'h22, 24'hFFFFFF);
		rd(8'h22, 24'h0);
		outs(24'hC04CFF, 5'h1F);
		wr(8'h20, 24'h0);
		outs(24'hCFFCFF, 5'h1F);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		outs(24'h0, 5'h0);
		rd(8'h21, 24'h0);
		wrap_up;
	end
endmodule // receiver_gain_config_regs_tb
